// file: hdl/mbs_map.sv
// address decode, mapping registers and external bus stretch control
//
// Operation
// - eeprom base bits give top four address bits of the eeprom
// - eeprom base writes once in normal modes, always in special, readable
// - read enable gates array reads only, never control or program access
// - read enable resets to one and is forced one in single chip
// - eeprom decoded only while read enable is one
// - flash sits in lower or upper half per half select
// - ram, registers, eeprom, debug rom override flash on overlap
// - misc register always readable, write once normal, any time special
// - half select zero low half, one high half; mode dependent reset
// - half select ignored while flash disabled
// - flash enable resets zero expanded, one single chip; gates flash
// - narrow follow bit picks 8-bit window bus in wide expanded only
// - follow window starts after 512-byte register block, moves with it
// - follow window stretch 0 to 3 clocks, ignored single chip, periph
// - external stretch 0 to 3 clocks, ignored single chip, periph
// - external bus 8 or 16 bits, low byte strobe marks width
// - only ram accesses show strobe and a0 both high
// - misaligned ram word: addressed byte high, next byte low
// - eeprom on 4K boundary, starts at 0d00 after reset
// - priority debug rom, registers, ram, eeprom, flash, then external
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module mbs_map
	import mbs_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        clk_en,
	// operating mode straps
	input  wire logic [1:0]  mode_sel,
	input  wire logic        special_mode,
	// register and ram positions and debug rom state from the rest of the chip
	input  wire logic [4:0]  reg_base_bits,
	input  wire logic [4:0]  ram_base_bits,
	input  wire logic        debug_rom_active,
	// avalon-mm slave
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// cpu side access
	input  wire logic        cpu_req,
	input  wire logic        cpu_write,
	input  wire logic        cpu_word,
	input  wire logic [15:0] cpu_addr,
	input  wire logic [15:0] cpu_wdata,
	output logic             cpu_ready,
	output logic      [2:0]  cpu_sel,
	output logic             cpu_array_read_en,
	// ram data lane steering
	input  wire logic [15:0] ram_rdata,
	output logic      [15:0] ram_rdata_swapped,
	// external bus
	output logic      [15:0] ext_addr,
	output logic      [15:0] ext_wdata,
	output logic             ext_rw,
	output logic             low_byte_strobe_n,
	output logic             ext_cycle,
	output logic             ext_narrow
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed
	{
		logic [7:0]   eeprom_position;
		logic [7:0]   misc_mapping_control;
		logic         ee_written;
		logic         misc_written;
		logic [2:0]   mode_s1;
		logic [2:0]   mode_s2;
		logic [2:0]   mode_s3;
		logic         reset_seen;
		logic [1:0]   settle;
		logic         ack;
		logic [31:0]  rdata;
		mbs_bus_st_t  bus_st;
		logic [1:0]   stretch_left;
		logic [15:0]  addr;
		logic [15:0]  wdata;
		logic         rw;
		logic         low_byte_strobe_n_n;
		logic         cycle;
		logic         narrow;
		logic         done;
		logic [2:0]   sel;
		logic [15:0]  ram_swap;
	} mbs_state_t;

	mbs_state_t state;
	mbs_state_t next_state;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic in_range(input logic [15:0] a, input logic [15:0] base, input logic [15:0] size);
		logic [16:0] top;
		top = {1'b0, base} + {1'b0, size};
		in_range = ({1'b0, a} >= {1'b0, base}) && ({1'b0, a} < top);
	endfunction

	function automatic logic [1:0] field2(input logic [7:0] r, input int lsb);
		field2 = r[lsb +: 2];
	endfunction

	// synchronised mode, second and third stage agree
	mbs_mode_t mode;
	logic      special;
	logic      single_chip;
	logic      no_stretch;
	logic      mode_stable;
	assign mode_stable = (state.mode_s2 == state.mode_s3);
	assign mode        = mbs_mode_t'(state.mode_s3[1:0]);
	assign special     = state.mode_s3[2];
	assign single_chip = (mode == MODE_SINGLE);
	assign no_stretch  = single_chip || (mode == MODE_PERIPH);

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	logic [15:0] reg_base;
	logic [15:0] ram_base;
	logic [15:0] ee_base;
	logic [15:0] follow_base;
	logic        ee_on;
	logic        flash_on;
	logic        flash_hi;
	logic        hit_follow;
	mbs_sel_t    sel;

	assign reg_base    = {reg_base_bits, 11'h000};
	assign ram_base    = {ram_base_bits, 11'h000};
	// eeprom sits at 0d00 offset inside its 4K block
	assign ee_base     = {state.eeprom_position[EE_BASE_LSB +: 4], EE_RESET_BASE[11:0]};
	assign follow_base = reg_base + REG_BLOCK_SIZE;
	assign ee_on       = state.eeprom_position[EE_ON_BIT] | single_chip;
	assign flash_on    = state.misc_mapping_control[FLASH_ENABLE_BIT];
	assign flash_hi    = state.misc_mapping_control[FLASH_HALF_SELECT_BIT];
	assign hit_follow  = in_range(cpu_addr, follow_base, REG_BLOCK_SIZE);

	always_comb
	begin
		// fixed order gives overlap priority
		if (debug_rom_active && in_range(cpu_addr, DBG_ROM_BASE, 16'h0100))
			sel = SEL_DEBUG;
		else if (in_range(cpu_addr, reg_base, REG_BLOCK_SIZE))
			sel = SEL_REGS;
		else if (in_range(cpu_addr, ram_base, RAM_SIZE))
			sel = SEL_RAM;
		// disabled eeprom falls through the map entirely
		else if (ee_on && in_range(cpu_addr, ee_base, EE_SIZE))
			sel = SEL_EE;
		else if (flash_on && (cpu_addr[FLASH_HALF_BIT] == flash_hi))
			sel = SEL_FLASH;
		else
			sel = SEL_EXT;
	end

	// control and program paths ignore this; only array reads are gated
	assign cpu_array_read_en = ee_on;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	logic        reg_hit_ee;
	logic        reg_hit_misc;
	logic        reg_hit_stat;
	logic        reg_hit_win;
	logic [1:0]  stretch;
	logic        wide_bus;
	assign reg_hit_ee   = (avs_address == REG_EEPROM_POSITION_IDX);
	assign reg_hit_misc = (avs_address == REG_MISC_MAPPING_IDX);
	assign reg_hit_stat = (avs_address == REG_MAP_STATUS_IDX);
	assign reg_hit_win  = (avs_address == REG_WINDOW_BASE_IDX);
	assign wide_bus     = (mode == MODE_WIDE);
	assign stretch      = no_stretch ? 2'h0 :
		(hit_follow ? field2(state.misc_mapping_control, RFSTR_LSB)
		            : field2(state.misc_mapping_control, EXSTR_LSB));

	always_comb
	begin
		next_state         = state;
		next_state.mode_s1 = {special_mode, mode_sel};
		next_state.mode_s2 = state.mode_s1;
		next_state.mode_s3 = state.mode_s2;
		next_state.ack     = 1'b0;
		next_state.done    = 1'b0;
		// mode dependent reset values once straps have settled
		// sync stages hold reset zeros at first, which would read as single chip
		if (state.settle != MODE_SETTLE_EDGES)
			next_state.settle = state.settle + 2'h1;
		if (!state.reset_seen && mode_stable && (state.settle == MODE_SETTLE_EDGES))
		begin
			next_state.reset_seen           = 1'b1;
			next_state.misc_mapping_control = single_chip ? MISC_RESET_SC : MISC_RESET_EXP;
		end
		// register bus: one wait state, then answer
		if ((avs_read || avs_write) && !state.ack && state.reset_seen)
		begin
			next_state.ack   = 1'b1;
			next_state.rdata = 32'h0000_0000;
			if (avs_read && reg_hit_ee)
				next_state.rdata = {24'h000000, state.eeprom_position[7:1], ee_on};
			if (avs_read && reg_hit_misc)
				next_state.rdata = {24'h000000, state.misc_mapping_control};
			if (avs_read && reg_hit_stat)
				next_state.rdata = {24'h000000, state.cycle, state.bus_st, state.sel, mode, special};
			if (avs_read && reg_hit_win)
				next_state.rdata = {16'h0000, follow_base};
		end
		// writes land only at the edge that sees waitrequest low
		if (avs_write && state.ack)
		begin
			if (avs_write && reg_hit_ee && (special || !state.ee_written))
			begin
				next_state.eeprom_position = avs_writedata[7:0] & EE_POS_MASK;
				next_state.ee_written      = 1'b1;
			end
			else if (avs_write && reg_hit_ee)
				// base locked after first write, enable stays free
				next_state.eeprom_position[EE_ON_BIT] = avs_writedata[EE_ON_BIT];
			if (avs_write && reg_hit_misc && (special || !state.misc_written))
			begin
				next_state.misc_mapping_control = avs_writedata[7:0] & MISC_MASK;
				next_state.misc_written         = 1'b1;
			end
		end
		// external bus engine
		unique case (state.bus_st)
			BUS_IDLE:
			begin
				next_state.cycle = 1'b0;
				if (cpu_req && !state.done)
				begin
					next_state.sel      = sel;
					next_state.addr     = cpu_addr;
					next_state.wdata    = cpu_wdata;
					next_state.rw       = !cpu_write;
					// odd word with strobe high only for ram
					next_state.low_byte_strobe_n_n  = cpu_word ? cpu_addr[0] && (sel == SEL_RAM) : !cpu_addr[0];
					next_state.ram_swap = cpu_addr[0] ? {ram_rdata[7:0], ram_rdata[15:8]} : ram_rdata;
					next_state.narrow   = (mode == MODE_NARROW) || (wide_bus && hit_follow
						&& state.misc_mapping_control[NARROW_FOLLOW_BIT_BIT]);
					if (sel == SEL_EXT && !single_chip)
					begin
						next_state.cycle = 1'b1;
						if (stretch != 2'h0)
						begin
							next_state.bus_st       = BUS_STRETCH;
							next_state.stretch_left = stretch;
						end
						else
							next_state.done = 1'b1;
					end
					else
						next_state.done = 1'b1;
				end
			end
			BUS_STRETCH:
			begin
				// address and control held while counting down
				next_state.stretch_left = state.stretch_left - 2'h1;
				if (state.stretch_left == 2'h1)
				begin
					next_state.bus_st = BUS_IDLE;
					next_state.done   = 1'b1;
				end
			end
		endcase
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state                      <= '0;
			state.eeprom_position      <= EE_POS_RESET;
			state.misc_mapping_control <= MISC_RESET_EXP;
			state.low_byte_strobe_n_n              <= 1'b1;
			state.rw                   <= 1'b1;
			state.bus_st               <= BUS_IDLE;
		end
		else if (clk_en)
			state <= next_state;
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign avs_readdata      = state.rdata;
	assign avs_waitrequest   = (avs_read || avs_write) && !state.ack;
	assign cpu_ready         = state.done;
	assign cpu_sel           = state.sel;
	assign ram_rdata_swapped = state.ram_swap;
	assign ext_addr          = state.addr;
	assign ext_wdata         = state.wdata;
	assign ext_rw            = state.rw;
	assign low_byte_strobe_n = state.low_byte_strobe_n_n;
	assign ext_cycle         = state.cycle;
	assign ext_narrow        = state.narrow;
endmodule

// file: hdl/mbs_pkg.sv
// constants and types for the memory map and bus stretch block
package mbs_pkg;
	// ------------------------------------------------------------
	// register map (index, byte address is four times the index)
	// ------------------------------------------------------------
	localparam logic [7:0]  REG_EEPROM_POSITION_IDX = 8'h12;
	localparam logic [7:0]  REG_MISC_MAPPING_IDX    = 8'h13;
	localparam logic [7:0]  REG_MAP_STATUS_IDX      = 8'h14;
	localparam logic [7:0]  REG_WINDOW_BASE_IDX     = 8'h15;
	// ------------------------------------------------------------
	// field positions and reset values
	// ------------------------------------------------------------
	localparam int          EE_BASE_LSB      = 4;
	localparam int          EE_ON_BIT        = 0;
	localparam logic [7:0]  EE_POS_RESET     = 8'h01;
	localparam logic [3:0]  EE_BASE_RESET    = 4'h0;
	localparam logic [7:0]  EE_POS_MASK      = 8'hf1;
	localparam int          NARROW_FOLLOW_BIT_BIT         = 6;
	localparam int          RFSTR_LSB        = 4;
	localparam int          EXSTR_LSB        = 2;
	localparam int          FLASH_HALF_SELECT_BIT       = 1;
	localparam int          FLASH_ENABLE_BIT        = 0;
	localparam logic [7:0]  MISC_MASK        = 8'h7f;
	localparam logic [7:0]  MISC_RESET_EXP   = 8'h0c;
	localparam logic [7:0]  MISC_RESET_SC    = 8'h0f;
	// edges after reset before the synchronised straps are trusted
	localparam logic [1:0]  MODE_SETTLE_EDGES = 2'h3;
	// ------------------------------------------------------------
	// address map sizes
	// ------------------------------------------------------------
	localparam logic [15:0] EE_RESET_BASE    = 16'h0d00;
	localparam logic [15:0] EE_SIZE          = 16'h0300;
	localparam logic [15:0] REG_BLOCK_SIZE   = 16'h0200;
	localparam logic [15:0] RAM_SIZE         = 16'h0400;
	localparam logic [15:0] DBG_ROM_BASE     = 16'hff00;
	localparam int          FLASH_HALF_BIT   = 15;
	localparam int          BLOCK2K_LSB      = 11;
	// ------------------------------------------------------------
	// enumerations
	// ------------------------------------------------------------
	typedef enum logic [2:0]
	{
		SEL_DEBUG = 3'b000,
		SEL_REGS  = 3'b001,
		SEL_RAM   = 3'b010,
		SEL_EE    = 3'b011,
		SEL_FLASH = 3'b100,
		SEL_EXT   = 3'b101
	} mbs_sel_t;
	typedef enum logic [1:0]
	{
		MODE_SINGLE = 2'b00,
		MODE_NARROW = 2'b01,
		MODE_WIDE   = 2'b10,
		MODE_PERIPH = 2'b11
	} mbs_mode_t;
	typedef enum logic [0:0]
	{
		BUS_IDLE    = 1'b0,
		BUS_STRETCH = 1'b1
	} mbs_bus_st_t;
endpackage

// file: dv/mbs_map_asserts.sv
// checker for decode priority and bus handshakes of the mapping block
`timescale 1ns/1ps
module mbs_map_asserts
	import mbs_pkg::*;
(
	// clock, reset, register base and debug rom state
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic [4:0]  reg_base_bits,
	input wire logic        debug_rom_active,
	// register bus
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic        avs_waitrequest,
	// cpu side and external bus
	input wire logic        cpu_req,
	input wire logic        cpu_write,
	input wire logic [15:0] cpu_addr,
	input wire logic        cpu_ready,
	input wire logic [2:0]  cpu_sel,
	input wire logic [15:0] ext_addr,
	input wire logic        ext_rw,
	input wire logic        low_byte_strobe_n,
	input wire logic        ext_cycle
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ------------------------------------------------------------
	// settle counter: bus is held while mode straps sync after reset
	// ------------------------------------------------------------
	logic [3:0] up;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			up <= 4'h0;
		else if (up != 4'hf)
			up <= up + 4'h1;
	end
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	a_one_wait: assert property (up == 4'hf && (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("register access not answered after one wait state");
	a_idle_nowait: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("waitrequest high with no request");
	a_ready_pulse: assert property (cpu_ready |=> !cpu_ready)
		else $error("cpu ready longer than one cycle");
	a_odd_strobe: assert property (ext_cycle |-> !(low_byte_strobe_n && ext_addr[0]))
		else $error("external cycle shows strobe and a0 both high");
	a_debug_first: assert property (cpu_ready && debug_rom_active && cpu_addr[15:8] == 8'hff |-> cpu_sel == SEL_DEBUG)
		else $error("active debug rom not selected");
	a_regs_win: assert property (cpu_ready && !(debug_rom_active && cpu_addr[15:8] == 8'hff)
		&& cpu_addr[15:9] == {reg_base_bits, 2'b00} |-> cpu_sel == SEL_REGS)
		else $error("register block not selected");
	a_ext_dir: assert property (cpu_ready && ext_cycle |-> ext_rw == !cpu_write)
		else $error("external direction does not follow access");
	a_stretch_hold: assert property (cpu_req && $past(cpu_req) && ext_cycle && !cpu_ready
		|=> $stable(ext_addr) && $stable(ext_rw))
		else $error("address or direction moved in a stretched cycle");
endmodule

bind mbs_map mbs_map_asserts mbs_map_asserts_inst (.clk, .rst_n, .reg_base_bits, .debug_rom_active, .avs_read,
	.avs_write, .avs_waitrequest, .cpu_req, .cpu_write, .cpu_addr, .cpu_ready, .cpu_sel, .ext_addr, .ext_rw,
	.low_byte_strobe_n, .ext_cycle);

// file: dv/mbs_ext_mem.sv
// expansion bus device model, records each external cycle it sees
`timescale 1ns/1ps
module mbs_ext_mem
(
	// clock
	input  wire logic        clk,
	// bus from the block
	input  wire logic [15:0] ext_addr,
	input  wire logic        ext_rw,
	input  wire logic        low_byte_strobe_n,
	input  wire logic        ext_cycle,
	// last cycle seen
	output logic      [15:0] seen_addr,
	output logic             seen_low_byte_strobe_n_n,
	output logic             seen_rw
);
	// strobe, address and direction are latched as driven; width is not decoded here
	always_ff @(posedge clk)
	begin
		if (ext_cycle)
		begin
			seen_addr    <= ext_addr;
			seen_low_byte_strobe_n_n <= low_byte_strobe_n;
			seen_rw      <= ext_rw;
		end
	end
endmodule

// file: dv/mbs_map_tb.sv
// self-checking bench for the memory map and bus stretch block
`timescale 1ns/1ps
module mbs_map_tb
	import mbs_pkg::*;
;
	logic        clk = 0, rst_n = 0, spec = 0, dbg = 0, rd = 0, wr = 0, req = 0, cw = 0, cwd = 0;
	logic [1:0]  mode = 2'b10;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wdat = 0, rdat, d;
	logic [15:0] caddr = 0, ram = 16'h1234, swp, eaddr, s_addr;
	logic [2:0]  sel;
	logic        waitreq, ready, erw, lsn, ecyc, s_lsn, s_rw, aren, narw;
	logic [15:0] ewd;
	logic [7:0]  tm [5] = '{8'h03, 8'h03, 8'h01, 8'h01, 8'h02};
	logic [15:0] ta [5] = '{16'h8000, 16'h4000, 16'h4000, 16'h0810, 16'h8000};
	logic [2:0]  ts [5] = '{SEL_FLASH, SEL_EXT, SEL_FLASH, SEL_RAM, SEL_EXT};
	int          miscompares = 0, cmp_count = 0, cyc = 0, n;
	always #25 clk = ~clk;
	mbs_map mbs_map_inst (.clk(clk), .rst_n(rst_n), .clk_en(1'b1), .mode_sel(mode), .special_mode(spec),
		.reg_base_bits(5'h00), .ram_base_bits(5'h01), .debug_rom_active(dbg), .avs_address(adr), .avs_read(rd),
		.avs_write(wr), .avs_writedata(wdat), .avs_readdata(rdat), .avs_waitrequest(waitreq), .cpu_req(req),
		.cpu_write(cw), .cpu_word(cwd), .cpu_addr(caddr), .cpu_wdata(16'hbeef), .cpu_ready(ready), .cpu_sel(sel),
		.cpu_array_read_en(aren), .ram_rdata(ram), .ram_rdata_swapped(swp), .ext_addr(eaddr), .ext_wdata(ewd),
		.ext_rw(erw), .low_byte_strobe_n(lsn), .ext_cycle(ecyc), .ext_narrow(narw));
	mbs_ext_mem mbs_ext_mem_inst (.clk(clk), .ext_addr(eaddr), .ext_rw(erw), .low_byte_strobe_n(lsn),
		.ext_cycle(ecyc), .seen_addr(s_addr), .seen_low_byte_strobe_n_n(s_lsn), .seen_rw(s_rw));
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
		adr <= a;
		rd  <= 1'b1;
		do @(posedge clk); while (waitreq !== 1'b0);
		v = rdat;
		rd <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
		adr  <= a;
		wdat <= v;
		wr   <= 1'b1;
		do @(posedge clk); while (waitreq !== 1'b0);
		wr <= 1'b0;
		@(posedge clk);
	endtask
	// k counts edges from the taking edge to the one that sees ready
	task automatic acc(input logic [15:0] a, input logic w, input logic wd, output int k);
		caddr <= a;
		cw    <= w;
		cwd   <= wd;
		req   <= 1'b1;
		k = 0;
		do begin @(posedge clk); k++; end while (ready !== 1'b1);
		req <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// ------------------------------------------------------------
	// timeout, far beyond the few hundred cycles the tests need
	// ------------------------------------------------------------
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			miscompares++;
			end_of_test();
		end
	end
	// ------------------------------------------------------------
	// tests, wide expanded mode so external memory is usable, single chip for the last checks
	// ------------------------------------------------------------
	initial
	begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge clk);
		rd_reg(8'h12, d); chk(d, 32'h01);
		rd_reg(8'h13, d); chk(d, 32'h0c);
		rd_reg(8'h40, d); chk(d, 32'h00);
		acc(16'h0d10, 1'b0, 1'b0, n); chk(sel, SEL_EE);
		wr_reg(8'h12, 32'h31); wr_reg(8'h12, 32'h51);
		rd_reg(8'h12, d); chk(d, 32'h31);
		acc(16'h3d10, 1'b0, 1'b0, n); chk(sel, SEL_EE);
		wr_reg(8'h12, 32'h30);
		acc(16'h3d10, 1'b0, 1'b0, n); chk(sel, SEL_EXT);
		chk(aren, 1'b0);
		wr_reg(8'h13, 32'h00); wr_reg(8'h13, 32'h0c);
		rd_reg(8'h13, d); chk(d, 32'h00);
		acc(16'h4001, 1'b1, 1'b0, n); chk({s_addr, s_lsn, s_rw}, {16'h4001, 2'b00});
		chk(ewd, 16'hbeef);
		acc(16'h4000, 1'b0, 1'b1, n); chk({s_lsn, s_rw}, 2'b01);
		acc(16'h4000, 1'b0, 1'b0, n); chk({s_lsn, s_rw}, 2'b11);
		acc(16'h0801, 1'b0, 1'b1, n); chk({sel, swp}, {SEL_RAM, 16'h3412});
		spec <= 1'b1;
		repeat (8) @(posedge clk);
		for (int i = 0; i < 5; i++)
		begin
			wr_reg(8'h13, {24'h0, tm[i]});
			acc(ta[i], 1'b0, 1'b0, n); chk(sel, ts[i]);
		end
		wr_reg(8'h13, 32'h03);
		dbg <= 1'b1;
		acc(16'hff10, 1'b0, 1'b0, n); chk(sel, SEL_DEBUG);
		dbg <= 1'b0;
		acc(16'hff10, 1'b0, 1'b0, n); chk(sel, SEL_FLASH);
		acc(16'h0010, 1'b0, 1'b0, n); chk(sel, SEL_REGS);
		for (int c = 0; c < 4; c++)
		begin
			wr_reg(8'h13, 32'(64 + c * 16 + (3 - c) * 4));
			acc(16'h0200, 1'b0, 1'b0, n); chk(n, c + 2);
			chk(narw, 1'b1);
			acc(16'h4000, 1'b0, 1'b0, n); chk(n, 5 - c);
			chk(narw, 1'b0);
		end
		mode <= 2'b00;
		repeat (8) @(posedge clk);
		wr_reg(8'h12, 32'h30);
		rd_reg(8'h12, d); chk(d, 32'h31);
		chk(aren, 1'b1);
		end_of_test();
	end
endmodule
